/* File: src/bfs_supervisor.sv */
// fault supervision, coast/brake decode and apb registers for a bridge driver
`timescale 1ns/10ps

// Summary of operation
// - all chop and rect low: all gates off
// - low chop and rect high: low-side brake
// - rect low: only one low side on
// - swapped chop levels brake via high sides
// - blank each active fet, then compare it
// - ignore comparator while off or blanking
// - monitor disable level stops all shorts
// - flags encode short, overtemp, undervoltage
// - simultaneous faults OR their flag patterns
// - which faults disable and which latch
// - overtemp raises flag a only, self-clears
// - regulator low disables, held from power-up
// - charge bootstrap via low side first
// - recharge if bootstrap drops while on
// - charge timeout latches undervoltage fault
// - logic undervoltage clears latched short and boot faults
// - logic undervoltage held from power-up
// - short after blanking latches, kills fet
// - low-side ds sense finds short to supply
// - high-side ds sense finds short to ground
// - shorted winding reported as short fault
// - short reset pulse clears latched faults
// - blank time is dead time plus margin
module bfs_supervisor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // host control and analog monitors
   input wire bfs_pkg::bfs_cmd_t cmd_in,
   input wire bfs_pkg::bfs_mon_t mon_in,
   // gate drives, bit order ha, la, hb, lb
   output logic [3:0] gate_drive,
   // open-drain fault flags
   input wire logic fault_flag_a_in,
   output logic fault_flag_a_out,
   output logic fault_flag_a_oe,
   input wire logic fault_flag_b_in,
   output logic fault_flag_b_out,
   output logic fault_flag_b_oe
);
   import bfs_pkg::*;

   // ==========================================================
   // input decode
   // ==========================================================
   // bridge pattern requested by the control pins
   function automatic logic [3:0] bfs_decode(input bfs_cmd_t c);
      logic [3:0] g;
      g = BFS_G_OFF;
      case ({c.high_side_chop_in, c.low_side_chop_in})
         2'b11: begin
            g = c.phase_dir ? BFS_G_AB : BFS_G_BA;
         end
         2'b01: begin
            // low-side recirculation
            if (c.sync_rect_enable) begin
               g = BFS_G_LS;
            end else begin
               g = c.phase_dir ? BFS_G_LB : BFS_G_LA;
            end
         end
         2'b10: begin
            // mirror image on the high sides
            if (c.sync_rect_enable) begin
               g = BFS_G_HS;
            end else begin
               g = c.phase_dir ? BFS_G_HA : BFS_G_HB;
            end
         end
         default: begin
            g = BFS_G_OFF;
         end
      endcase
      return g;
   endfunction

   // ==========================================================
   // monitor synchronisers
   // ==========================================================
   bfs_mon_t mon_meta_reg;       // first stage, read only by stage two
   bfs_mon_t mon_reg;            // safe, synchronised copy

   // undervoltage bits come up asserted so the bridge stays off
   // until the supplies have been seen good after power-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_meta_reg <= '{default: 1'b0, regulator_uv: 1'b1, logic_uv: 1'b1};
         mon_reg <= '{default: 1'b0, regulator_uv: 1'b1, logic_uv: 1'b1};
      end else begin
         mon_meta_reg <= mon_in;
         mon_reg <= mon_meta_reg;
      end
   end

   // ==========================================================
   // registers and shared state
   // ==========================================================
   logic drive_en_reg;           // software bridge enable
   logic [7:0] dead_cyc_reg;     // dead time in pclk cycles
   logic [3:0] gate_reg;         // registered gate drives
   logic [3:0] short_reg;        // latched short per fet
   logic [1:0] boot_flt_reg;     // latched bootstrap fault per phase
   logic flag_a_oe_reg;          // flag a pull-down, low on fault
   logic flag_b_oe_reg;
   logic [3:0] qual;             // comparator not masked
   logic [3:0] demand;           // decoded bridge request
   logic [3:0] gate_next;
   logic [1:0] charging;         // phase in bootstrap charge
   logic [1:0] hs_ok;            // high side may be driven
   logic [1:0] boot_to;          // charge cycle timed out
   logic uv_any;
   logic disable_all;
   logic [8:0] blank_lim;

   assign demand = bfs_decode(cmd_in);
   assign uv_any = mon_reg.logic_uv | mon_reg.regulator_uv | (|boot_flt_reg);
   // every disabling fault forces all gates low
   assign disable_all = uv_any | (|short_reg) | ~drive_en_reg;
   // blank covers dead time plus comparator latency
   assign blank_lim = {1'b0, dead_cyc_reg} + 9'(BFS_BLANK_EXTRA_CYC);

   // ==========================================================
   // bootstrap sequencer, one per phase
   // ==========================================================
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_boot
         bfs_boot_t st_reg;                // sequencer state
         logic [7:0] cnt_reg;              // charge time counter
         logic want_hs;
         assign want_hs = demand[2 * p];
         assign charging[p] = (st_reg == BS_CHARGE);
         assign hs_ok[p] = (st_reg == BS_ON) & want_hs;
         assign boot_to[p] = charging[p] & want_hs & mon_reg.boot_below_on[p]
            & (cnt_reg == 8'(BFS_BOOT_TO_CYC - 1));

         // charge before turning on, recharge on droop
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st_reg <= BS_IDLE;
               cnt_reg <= 8'h00;
            end else begin
               case (st_reg)
                  BS_IDLE: begin
                     cnt_reg <= 8'h00;
                     if (want_hs && !disable_all) begin
                        // low bootstrap: charge via low side
                        st_reg <= mon_reg.boot_below_on[p] ? BS_CHARGE : BS_ON;
                     end
                  end
                  BS_ON: begin
                     cnt_reg <= 8'h00;
                     if (!want_hs) begin
                        st_reg <= BS_IDLE;
                     end else if (mon_reg.boot_below_off[p]) begin
                        st_reg <= BS_CHARGE;
                     end
                  end
                  BS_CHARGE: begin
                     cnt_reg <= cnt_reg + 8'h01;
                     if (!want_hs || disable_all || boot_to[p]) begin
                        st_reg <= BS_IDLE;
                     end else if (!mon_reg.boot_below_on[p]) begin
                        st_reg <= BS_ON;
                     end
                  end
                  default: begin
                     st_reg <= BS_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   // bootstrap faults latch until reset; logic undervoltage wipes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_flt_reg <= 2'b00;
      end else if (mon_reg.logic_uv) begin
         boot_flt_reg <= 2'b00;
      end else begin
         boot_flt_reg <= boot_flt_reg | boot_to;
      end
   end

   // ==========================================================
   // gate drive
   // ==========================================================
   // high sides wait for the sequencer; a charge pulse on the low side
   // is dropped as soon as its high side is no longer wanted, so coast wins
   always_comb begin
      gate_next = BFS_G_OFF;
      if (!disable_all) begin
         gate_next[BFS_HA] = hs_ok[0];
         gate_next[BFS_LA] = demand[BFS_LA] | (charging[0] & demand[BFS_HA]);
         gate_next[BFS_HB] = hs_ok[1];
         gate_next[BFS_LB] = demand[BFS_LB] | (charging[1] & demand[BFS_HB]);
         gate_next = gate_next & ~short_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_reg <= BFS_G_OFF;
      end else begin
         gate_reg <= gate_next;
      end
   end

   // ==========================================================
   // blanking and short detection, one per fet
   // ==========================================================
   genvar f;
   generate
      for (f = 0; f < 4; f++) begin : g_fet
         logic [8:0] blank_reg;            // cycles since turn-on
         // counter sits at zero while the fet is off
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               blank_reg <= 9'h000;
            end else if (!gate_reg[f]) begin
               blank_reg <= 9'h000;
            end else if (blank_reg < blank_lim) begin
               blank_reg <= blank_reg + 9'h001;
            end
         end
         assign qual[f] = gate_reg[f] & (blank_reg >= blank_lim);

         // even index: high side, short to ground; odd: low side,
         // short to supply; a shorted winding trips either or both
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               short_reg[f] <= 1'b0;
            end else if (mon_reg.logic_uv) begin
               short_reg[f] <= 1'b0;
            end else if (qual[f] && mon_reg.vds_over[f] && !mon_reg.mon_disable) begin
               short_reg[f] <= 1'b1;
            end
         end
      end
   endgenerate

   // ==========================================================
   // fault flags
   // ==========================================================
   // overtemp only touches flag a, undervoltage sets both
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_a_oe_reg <= 1'b1;
         flag_b_oe_reg <= 1'b1;
      end else begin
         flag_a_oe_reg <= ~(mon_reg.overtemp | uv_any);
         flag_b_oe_reg <= ~((|short_reg) | uv_any);
      end
   end

   // open drain: pull low when no fault, release high on fault
   assign fault_flag_a_out = 1'b0;
   assign fault_flag_b_out = 1'b0;
   assign fault_flag_a_oe = flag_a_oe_reg;
   assign fault_flag_b_oe = flag_b_oe_reg;
   assign gate_drive = gate_reg;

   // ==========================================================
   // apb slave
   // ==========================================================
   logic [31:0] rdata_reg;       // read data, set in setup phase
   logic err_reg;                // error for unmapped address
   logic setup;
   logic [31:0] stat_word;
   assign setup = psel & ~penable;
   assign prdata = rdata_reg;
   assign pready = 1'b1;         // zero wait states, constant
   assign pslverr = err_reg;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[BFS_ST_SHORT +: 4] = short_reg;
      stat_word[BFS_ST_BOOT +: 2] = boot_flt_reg;
      stat_word[BFS_ST_OT] = mon_reg.overtemp;
      stat_word[BFS_ST_GATE_REGULATOR_SUPPLY] = mon_reg.regulator_uv;
      stat_word[BFS_ST_LOGIC] = mon_reg.logic_uv;
      stat_word[BFS_ST_MDIS] = mon_reg.mon_disable;
      stat_word[BFS_ST_FLAGS +: 2] = {fault_flag_b_in, fault_flag_a_in};
   end

   // read data and error are prepared during setup for a zero-wait access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else if (setup) begin
         err_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         case (paddr)
            BFS_CTRL_ADDR: begin
               rdata_reg[BFS_EN_BIT] <= drive_en_reg;
               rdata_reg[BFS_DEAD_MSB:BFS_DEAD_LSB] <= dead_cyc_reg;
            end
            BFS_STAT_ADDR: begin
               rdata_reg <= stat_word;
            end
            BFS_GATE_ADDR: begin
               rdata_reg[3:0] <= gate_reg;
            end
            default: begin
               err_reg <= 1'b1;
            end
         endcase
      end
   end

   // control writes take effect at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_en_reg <= BFS_EN_RST;
         dead_cyc_reg <= BFS_DEAD_RST;
      end else if (psel && penable && pwrite && paddr == BFS_CTRL_ADDR) begin
         drive_en_reg <= pwdata[BFS_EN_BIT];
         dead_cyc_reg <= pwdata[BFS_DEAD_MSB:BFS_DEAD_LSB];
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_COAST: assert property (demand == BFS_G_OFF |=> gate_reg == BFS_G_OFF)
      else $error("coast did not turn all gates off");
   AST_LS_BRAKE: assert property (cmd_in.sync_rect_enable
      && cmd_in.low_side_chop_in && !cmd_in.high_side_chop_in && !disable_all
      && short_reg == 4'h0 |=> gate_reg == BFS_G_LS)
      else $error("low-side brake pattern wrong");
   AST_ONE_LS: assert property (!cmd_in.sync_rect_enable
      && cmd_in.low_side_chop_in && !cmd_in.high_side_chop_in && !disable_all
      |=> !(gate_reg[BFS_LA] && gate_reg[BFS_LB]))
      else $error("both low sides on without rectification");
   AST_HS_BRAKE: assert property (cmd_in.sync_rect_enable
      && cmd_in.high_side_chop_in && !cmd_in.low_side_chop_in && charging == 2'b00
      |=> !gate_reg[BFS_LA] && !gate_reg[BFS_LB])
      else $error("high-side brake drove a low side");
   AST_DISABLE: assert property (disable_all |=> gate_reg == BFS_G_OFF)
      else $error("gates on while disabled");
   AST_BLANK: assert property ($rose(gate_reg[BFS_LA]) |-> !qual[BFS_LA] [*8])
      else $error("comparator used inside blank time");
   AST_MONDIS: assert property (mon_reg.mon_disable && !mon_reg.logic_uv
      |=> short_reg == $past(short_reg))
      else $error("short latched while monitor disabled");
   // sampled reset keeps the release edge out: flags still hold reset levels there
   AST_FLAGS: assert property (presetn && uv_any
      |=> !fault_flag_a_oe && !fault_flag_b_oe)
      else $error("undervoltage did not release both flags");
   AST_FLAG_OT: assert property (mon_reg.overtemp && !uv_any
      && short_reg == 4'h0 |=> !fault_flag_a_oe && fault_flag_b_oe)
      else $error("overtemperature flag pattern wrong");
   AST_FLAG_SHORT: assert property (short_reg != 4'h0 && !uv_any
      && !mon_reg.overtemp |=> fault_flag_a_oe && !fault_flag_b_oe)
      else $error("short flag pattern wrong");
   AST_LOGIC_UV: assert property (mon_reg.logic_uv |=> short_reg == 4'h0
      && boot_flt_reg == 2'b00 && gate_reg == BFS_G_OFF)
      else $error("logic undervoltage left faults or gates");
   AST_BOOT_TO: assert property (boot_to[0] && !mon_reg.logic_uv
      |=> boot_flt_reg[0] ##2 gate_reg == BFS_G_OFF)
      else $error("bootstrap timeout not latched");

   CV_SHORT: cover property ($rose(|short_reg));
   CV_BOOT: cover property ($rose(|boot_flt_reg));
   CV_LS_BRAKE: cover property (gate_reg == BFS_G_LS);
   CV_RECHARGE: cover property (g_boot[0].st_reg == BS_ON ##1 g_boot[0].st_reg == BS_CHARGE);

endmodule // bfs_supervisor

/* File: src/bfs_pkg.sv */
// package of constants and types for the bridge fault supervisor
package bfs_pkg;

   // ==========================================================
   // apb register map
   // ==========================================================
   localparam logic [7:0] BFS_CTRL_ADDR = 8'h00;   // control word
   localparam logic [7:0] BFS_STAT_ADDR = 8'h04;   // fault state, read only
   localparam logic [7:0] BFS_GATE_ADDR = 8'h08;   // gate drives, read only
   localparam int BFS_EN_BIT = 0;                  // ctrl: drive enable
   localparam int BFS_DEAD_LSB = 8;                // ctrl: dead time field
   localparam int BFS_DEAD_MSB = 15;
   localparam logic BFS_EN_RST = 1'b1;             // bridge allowed after reset
   localparam logic [7:0] BFS_DEAD_RST = 8'h04;    // dead time in cycles
   localparam int BFS_ST_SHORT = 0;                // status: short latches 3:0
   localparam int BFS_ST_BOOT = 4;                 // status: boot faults 5:4
   localparam int BFS_ST_OT = 6;
   localparam int BFS_ST_GATE_REGULATOR_SUPPLY = 7;
   localparam int BFS_ST_LOGIC = 8;
   localparam int BFS_ST_MDIS = 9;
   localparam int BFS_ST_FLAGS = 10;               // flag pin readback 11:10

   // ==========================================================
   // gate drive indices and drive patterns
   // ==========================================================
   localparam int BFS_HA = 0;
   localparam int BFS_LA = 1;
   localparam int BFS_HB = 2;
   localparam int BFS_LB = 3;
   localparam logic [3:0] BFS_G_OFF = 4'h0;
   localparam logic [3:0] BFS_G_LS = 4'hA;         // both low sides
   localparam logic [3:0] BFS_G_HS = 4'h5;         // both high sides
   localparam logic [3:0] BFS_G_AB = 4'h9;         // a high, b low
   localparam logic [3:0] BFS_G_BA = 4'h6;         // b high, a low
   localparam logic [3:0] BFS_G_LA = 4'h2;
   localparam logic [3:0] BFS_G_LB = 4'h8;
   localparam logic [3:0] BFS_G_HA = 4'h1;
   localparam logic [3:0] BFS_G_HB = 4'h4;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int BFS_CLK_NS = 50;                 // pclk period
   localparam int BFS_BLANK_EXTRA_NS = 600;        // comparator latency margin
   localparam int BFS_BLANK_EXTRA_CYC = (BFS_BLANK_EXTRA_NS + BFS_CLK_NS - 1) / BFS_CLK_NS;
   localparam int BFS_BOOT_TO_NS = 10000;          // bootstrap charge timeout
   localparam int BFS_BOOT_TO_CYC = BFS_BOOT_TO_NS / BFS_CLK_NS;

   // ==========================================================
   // types
   // ==========================================================
   // host control pins
   typedef struct packed {
      logic high_side_chop_in;
      logic low_side_chop_in;
      logic sync_rect_enable;
      logic phase_dir;
   } bfs_cmd_t;

   // analog monitor results, all asynchronous
   typedef struct packed {
      logic [3:0] vds_over;        // ds voltage above threshold, per fet
      logic [1:0] boot_below_on;   // bootstrap below turn-on limit
      logic [1:0] boot_below_off;  // bootstrap below turn-off limit
      logic mon_disable;           // threshold above monitor_disable_level
      logic overtemp;
      logic regulator_uv;          // gate_regulator_supply low
      logic logic_uv;              // logic_supply low
   } bfs_mon_t;

   // bootstrap sequencer states
   typedef enum logic [2:0] {
      BS_IDLE = 3'b001,
      BS_CHARGE = 3'b010,
      BS_ON = 3'b100
   } bfs_boot_t;

endpackage

/* File: verification/bfs_host_model.sv */
// host controller model driving the bridge command and reset pins
`timescale 1ns/10ps
module bfs_host_model (
   // clock
   input wire logic pclk,
   // requests from the bench
   input wire bfs_pkg::bfs_cmd_t cmd_req,
   input wire logic pulse_req,
   // pins toward the device
   output bfs_pkg::bfs_cmd_t cmd_in,
   output logic rst_pulse_n
);
   import bfs_pkg::*;
   // ==========================================
   // pin drive
   // ==========================================
   // idle is the all-low command, so the bridge coasts until asked otherwise
   initial cmd_in = '0;
   initial rst_pulse_n = 1'b1;
   // a single low cycle clears latches without a long sleep entry
   always @(posedge pclk) begin
      cmd_in <= cmd_req;
      rst_pulse_n <= ~pulse_req;
   end
endmodule // bfs_host_model

/* File: verification/tb.sv */
// self-checking bench for the bridge fault supervisor
`timescale 1ns/10ps
module tb;
   import bfs_pkg::*;
   // ==========================================
   // signals
   // ==========================================
   logic pclk = 1'b0;
   logic rst_n = 1'b0; // bench reset
   logic host_rst_n; // short pulses from the host
   logic presetn;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, fa_oe, fb_oe, fa_out, fb_out, pin_a, pin_b;
   logic [3:0] gate_drive;
   bfs_cmd_t cmd_req = '0;
   bfs_cmd_t cmd_in;
   bfs_mon_t mon_in = '0;
   logic pulse_req = 1'b0;
   logic obs = 1'b0; // a toggle asks the watcher for one compare
   logic obs_seen = 1'b0;
   logic [33:0] q[$]; // notes: kind, expected value
   logic [33:0] note;
   logic [31:0] got;
   int n_fail = 0;
   int n_compared = 0;
   int seed = 73;
   int cyc = 0;
   int ph;
   // xph, command, gates; xph marks phase as ignored
   logic [8:0] tbl[7] = '{9'h100, 9'h16A, 9'h058, 9'h042, 9'h0D9, 9'h0C6, 9'h1A5};
   // flag pins are pulled up when released
   assign pin_a = fa_oe ? fa_out : 1'b1;
   assign pin_b = fb_oe ? fb_out : 1'b1;
   assign presetn = rst_n & host_rst_n;
   always #25 pclk = ~pclk;
   // ==========================================
   // instances
   // ==========================================
   bfs_supervisor u_bfs_supervisor (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_in, .mon_in, .gate_drive,
      .fault_flag_a_in(pin_a), .fault_flag_a_out(fa_out), .fault_flag_a_oe(fa_oe),
      .fault_flag_b_in(pin_b), .fault_flag_b_out(fb_out), .fault_flag_b_oe(fb_oe));
   bfs_host_model u_bfs_host_model (.pclk, .cmd_req, .pulse_req, .cmd_in,
      .rst_pulse_n(host_rst_n));
   // ==========================================
   // tasks
   // ==========================================
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // kind 0 pins, 1 read data, 2 error response
   task automatic chk(input logic [1:0] k, input logic [31:0] v);
      q.push_back({k, v});
      obs <= ~obs;
   endtask
   // pins: bit 5 flag b, bit 4 flag a, 3:0 gates
   task automatic pins(input logic [5:0] v, input int wait_n);
      tick(wait_n);
      chk(2'h0, {26'h0, v});
      tick(1);
   endtask
   // zero-wait slave, but the access edge still waits for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] k, input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      if (k != 2'h0) chk(k, v);
      tick(1);
      while (pready !== 1'b1) tick(1);
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask
   // ==========================================
   // watcher and timeout
   // ==========================================
   always @(posedge pclk) begin
      if (obs !== obs_seen) begin
         obs_seen = obs;
         note = q.pop_front();
         got = (note[33:32] == 2'h1) ? prdata : (note[33:32] == 2'h2) ?
            {31'h0, pslverr} : {26'h0, pin_b, pin_a, gate_drive};
         n_compared++;
         if (got !== note[31:0]) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, note[31:0]);
         end
      end
   end
   // the whole run takes well under a thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         print_verdict();
      end
   end
   // ==========================================
   // main sequence
   // ==========================================
   initial begin
      tick(4);
      rst_n <= 1'b1;
      tick(8);
      apb(1'b0, BFS_CTRL_ADDR, 32'h0, 2'h1, 32'h0000_0401);
      for (int i = 0; i < 7; i++) begin
         ph = $random(seed);
         cmd_req <= bfs_cmd_t'(tbl[i][7:4] | {3'b000, tbl[i][8] & ph[0]});
         pins({2'b00, tbl[i][3:0]}, 8);
      end
      // read-only and unmapped places, then the drive enable
      apb(1'b1, BFS_STAT_ADDR, $random(seed), 2'h0, 32'h0);
      apb(1'b0, BFS_GATE_ADDR, 32'h0, 2'h1, 32'h5);
      apb(1'b0, 8'h0C, 32'h0, 2'h2, 32'h1);
      apb(1'b1, BFS_CTRL_ADDR, 32'h0400, 2'h0, 32'h0);
      pins(6'h00, 3);
      apb(1'b1, BFS_CTRL_ADDR, 32'h0401, 2'h0, 32'h0);
      // bootstrap sags while high sides run, then stays low past the charge timeout
      mon_in.boot_below_off <= 2'b11;
      mon_in.boot_below_on <= 2'b11;
      pins(6'h0A, 8);
      pins(6'h30, 210);
      mon_in.boot_below_off <= 2'b00;
      mon_in.boot_below_on <= 2'b00;
      pins(6'h30, 6);
      apb(1'b0, BFS_STAT_ADDR, 32'h0, 2'h1, 32'h0000_0C30);
      pulse_req <= 1'b1;
      tick(1);
      pulse_req <= 1'b0;
      pins(6'h05, 10);
      // comparator noise inside blanking and on an off fet
      cmd_req <= bfs_cmd_t'(4'h6);
      mon_in.vds_over <= 4'h3;
      tick(8);
      mon_in.vds_over <= 4'h1;
      pins(6'h0A, 30);
      mon_in.mon_disable <= 1'b1;
      mon_in.vds_over <= 4'h2;
      pins(6'h0A, 6);
      mon_in.mon_disable <= 1'b0;
      mon_in.vds_over <= 4'h0;
      mon_in.overtemp <= 1'b1;
      pins(6'h1A, 5);
      mon_in.vds_over <= 4'h8;
      pins(6'h30, 6);
      mon_in.overtemp <= 1'b0;
      mon_in.vds_over <= 4'h0;
      pins(6'h20, 6);
      pulse_req <= 1'b1;
      tick(1);
      pulse_req <= 1'b0;
      pins(6'h0A, 10);
      // high-side short, then a logic supply dip wipes it
      cmd_req <= bfs_cmd_t'(4'hA);
      tick(30);
      mon_in.vds_over <= 4'h4;
      pins(6'h20, 6);
      mon_in.logic_uv <= 1'b1;
      mon_in.vds_over <= 4'h0;
      pins(6'h30, 5);
      mon_in.logic_uv <= 1'b0;
      pins(6'h05, 10);
      mon_in.regulator_uv <= 1'b1;
      pins(6'h30, 5);
      mon_in.regulator_uv <= 1'b0;
      pins(6'h05, 8);
      // let the watcher take the last note before the verdict
      tick(2);
      if (q.size() != 0) n_fail++;
      print_verdict();
   end
endmodule // tb
